// [hw/wqw_pkg.sv]
`default_nettype none
// shared constants and types for the windowed question-answer watchdog
package wqw_pkg;
    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] TIMING_CFG_ADDR   = 8'h13; // mode, prescale, divider
    localparam logic [7:0] WINDOW_CFG_ADDR   = 8'h14; // closed and open lengths
    localparam logic [7:0] ENABLE_CFG_ADDR   = 8'h15; // watchdog_enable_and_extension
    localparam logic [7:0] SERVICE_KEY_ADDR  = 8'h16; // service_key
    localparam logic [7:0] GUARD_ADDR        = 8'h17; // watchdog_config_guard
    localparam logic [7:0] STATUS_ADDR       = 8'h18; // failure status
    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int WINDOW_KIND_BIT     = 7; // 0 question_answer, 1 simple
    localparam int TICK_PRESCALE_BIT   = 6;
    localparam int TICK_DIVIDER_MSB    = 5;
    localparam int CLOSED_LEN_MSB      = 7;
    localparam int CLOSED_LEN_LSB      = 4;
    localparam int OPEN_LEN_MSB        = 3;
    localparam int THRESHOLD_BIT       = 4; // 0 one failure, 1 two failures
    localparam int WATCHDOG_ON_BIT     = 3;
    localparam int EXTENSION_MSB       = 2;
    localparam int GUARD_BIT           = 0;
    localparam int FAULT_BIT           = 0; // status: threshold reached
    localparam int VIOLATION_BIT       = 1; // status: key_sequence_violation
    localparam int TIMEOUT_BIT         = 2; // status: open window expired
    localparam int FAIL_COUNT_LSB      = 3; // status: live failure count
    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CFG_RESET       = 8'h00;
    localparam logic [7:0] KEY_RESET       = 8'h01; // lfsr seed, never zero
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS        = 8;
    localparam int TICK_BASE_TIME_NS    = 128000; // 128 us
    localparam int TICK_BASE_CYCLES     = (TICK_BASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRESCALE_FACTOR      = 64;
    localparam int WINDOW_FACTOR        = 8;
    ////////////////////////////////////////////////////////////////////////
    // window phase
    typedef enum logic {
        CLOSED_PHASE,
        OPEN_PHASE
    } wqw_phase_type;

    // next key: x^8 + x^6 + x^5 + x^4 + 1, shift left, feedback into bit 0
    function automatic logic [7:0] lfsr_next(input logic [7:0] cur);
        lfsr_next = {cur[6:0], cur[7] ^ cur[5] ^ cur[4] ^ cur[3]};
    endfunction
endpackage
`default_nettype wire

// [hw/wqw_tick_gen.sv]
`timescale 1ns/10ps
`default_nettype none
// watchdog tick enable: (divider+1) x base, base is 128 us or 64 x 128 us
module wqw_tick_gen #(
    parameter int BASE_CYCLES = wqw_pkg::TICK_BASE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       run,         // counters held clear while low
    input  wire logic       prescale,    // tick_prescale
    input  wire logic [5:0] divider,     // tick_divider
    output logic            tick         // one-cycle pulse
);
    localparam logic [15:0] BASE_LAST  = 16'(BASE_CYCLES - 1);
    localparam logic [5:0]  SCALE_LAST = 6'(wqw_pkg::PRESCALE_FACTOR - 1);

    typedef struct packed {
        logic [15:0] baseCount;  // clk cycles inside one base period
        logic [5:0]  scaleCount; // base periods inside one prescaled period
        logic [5:0]  divCount;   // prescaled periods inside one tick
        logic        tick;       // registered pulse
    } wqw_tick_state_type;

    wqw_tick_state_type state_reg;
    wqw_tick_state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    // divider chain
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (!run) begin
            state_next.baseCount  = 16'h0000;
            state_next.scaleCount = 6'h00;
            state_next.divCount   = 6'h00;
        end else if (state_reg.baseCount != BASE_LAST) begin
            state_next.baseCount = state_reg.baseCount + 16'h0001;
        end else begin
            state_next.baseCount = 16'h0000;
            // base period complete; prescaled period complete if prescale is off or scaleCount is at SCALE_LAST
            if (!prescale || state_reg.scaleCount == SCALE_LAST) begin
                state_next.scaleCount = 6'h00;
                // a lowered divider must not let the count run past it and wrap
                if (state_reg.divCount >= divider) begin
                    state_next.divCount = 6'h00;
                    state_next.tick     = 1'b1;
                end else begin
                    state_next.divCount = state_reg.divCount + 6'h01;
                end
            end else begin
                state_next.scaleCount = state_reg.scaleCount + 6'h01;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule // wqw_tick_gen
`default_nettype wire

// [hw/wqw_watchdog_regs.sv]
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - watchdog runs only while enable bit set
// - first cycle windows stretched by extension plus one
// - key register read returns current key
// - simple mode: any key write refreshes, key kept
// - wrong answer discarded, flags sequence violation
// - right answer in open window refreshes, advances
// - right answer in closed window is violation
// - key sequence from x8+x6+x5+x4+1 lfsr
// - guard bit makes configuration registers read-only
// - threshold reached drives reset low, sets status
// - threshold bit: one failure or two failures
// - window length is (field+1) x 8 ticks
// - tick is (divider+1) x 128us or x64
// - mode bit: 0 question-answer, 1 simple
module wqw_watchdog_regs #(
    parameter int BASE_CYCLES = wqw_pkg::TICK_BASE_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] regAddr,         // register offset
    input  wire logic       regWrite,        // one-cycle write strobe
    input  wire logic [7:0] regWriteData,
    input  wire logic       regRead,         // one-cycle read strobe
    output logic      [7:0] regReadData,     // valid the cycle after regRead
    output logic            systemResetOut_n // watchdog fault reset
);
    typedef struct packed {
        logic [7:0]            timingCfg;   // mode, prescale, divider
        logic [7:0]            windowCfg;   // closed and open lengths
        logic [7:0]            enableCfg;   // threshold, enable, extension
        logic                  guard;       // config_write_guard
        logic [7:0]            key;         // service_key_reg
        logic [2:0]            flags;       // fault, violation, timeout
        logic [7:0]            readData;
        wqw_pkg::wqw_phase_type phase;
        logic [11:0]           winCount;    // ticks spent in current window
        logic                  firstCycle;  // still in the window cycle after reset
        logic [1:0]            failCount;
        logic                  resetOut_n;
    } wqw_state_type;

    wqw_state_type state_reg;
    wqw_state_type state_next;

    logic       tick;
    logic       watchdogOn;
    logic       simpleMode;
    logic       keyWrite;
    logic [7:0] expectedKey;
    logic       answerRight;
    logic [3:0] stretch;
    logic [11:0] closedLen;
    logic [11:0] openLen;

    // window length in ticks: (field + 1) x 8 x stretch
    function automatic logic [11:0] window_len(input logic [3:0] field,
                                               input logic [3:0] mult);
        logic [11:0] base;
        base = {4'h0, 5'({1'b0, field} + 5'h01), 3'h0};
        window_len = 12'(base * {8'h00, mult});
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decoded controls
    assign watchdogOn  = state_reg.enableCfg[wqw_pkg::WATCHDOG_ON_BIT];
    assign simpleMode  = state_reg.timingCfg[wqw_pkg::WINDOW_KIND_BIT];
    assign keyWrite    = regWrite && regAddr == wqw_pkg::SERVICE_KEY_ADDR && watchdogOn;
    assign expectedKey = wqw_pkg::lfsr_next(state_reg.key);
    assign answerRight = regWriteData == expectedKey;
    // first cycle stretch
    assign stretch     = state_reg.firstCycle ?
                         {1'b0, state_reg.enableCfg[wqw_pkg::EXTENSION_MSB:0]} + 4'h1 : 4'h1;
    assign closedLen   = window_len(state_reg.windowCfg[wqw_pkg::CLOSED_LEN_MSB:
                                                        wqw_pkg::CLOSED_LEN_LSB], stretch);
    assign openLen     = window_len(state_reg.windowCfg[wqw_pkg::OPEN_LEN_MSB:0], stretch);

    ////////////////////////////////////////////////////////////////////////
    // tick source
    wqw_tick_gen #(
        .BASE_CYCLES (BASE_CYCLES)
    ) u_tick (
        .clk      (clk),
        .reset_n  (reset_n),
        .run      (watchdogOn),
        .prescale (state_reg.timingCfg[wqw_pkg::TICK_PRESCALE_BIT]),
        .divider  (state_reg.timingCfg[wqw_pkg::TICK_DIVIDER_MSB:0]),
        .tick     (tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic       refresh;
        logic       violation;
        logic       timeout;
        logic [1:0] failLimit;
        logic [1:0] failSum;
        refresh   = 1'b0;
        violation = 1'b0;
        timeout   = 1'b0;
        failLimit = state_reg.enableCfg[wqw_pkg::THRESHOLD_BIT] ? 2'h2 : 2'h1;
        failSum   = 2'h0;
        state_next = state_reg;

        // configuration writes, blocked by the guard
        if (regWrite && !state_reg.guard) begin
            unique case (regAddr)
                wqw_pkg::TIMING_CFG_ADDR: state_next.timingCfg = regWriteData;
                wqw_pkg::WINDOW_CFG_ADDR: state_next.windowCfg = regWriteData;
                wqw_pkg::ENABLE_CFG_ADDR: state_next.enableCfg = {3'h0, regWriteData[4:0]};
                default: ;
            endcase
        end
        // guard sets once and holds until reset
        if (regWrite && regAddr == wqw_pkg::GUARD_ADDR && regWriteData[wqw_pkg::GUARD_BIT]) begin
            state_next.guard = 1'b1;
        end
        // write one to clear status flags; a new event below wins
        if (regWrite && regAddr == wqw_pkg::STATUS_ADDR) begin
            state_next.flags = state_reg.flags & ~regWriteData[2:0];
        end

        // key service
        if (keyWrite) begin
            if (simpleMode) begin
                refresh = 1'b1;
            end else if (!answerRight) begin
                violation = 1'b1;
            end else if (state_reg.phase == wqw_pkg::OPEN_PHASE) begin
                refresh = 1'b1;
                state_next.key = expectedKey;
            end else begin
                violation = 1'b1;
            end
        end

        // window sequencing
        if (!watchdogOn) begin
            state_next.phase    = wqw_pkg::CLOSED_PHASE;
            state_next.winCount = 12'h000;
            state_next.failCount = 2'h0;
            state_next.resetOut_n = 1'b1;
        end else if (refresh) begin
            state_next.phase      = wqw_pkg::CLOSED_PHASE;
            state_next.winCount   = 12'h000;
            state_next.firstCycle = 1'b0;
        end else if (tick) begin
            if (state_reg.phase == wqw_pkg::CLOSED_PHASE &&
                state_reg.winCount >= closedLen - 12'h001) begin
                state_next.phase    = wqw_pkg::OPEN_PHASE;
                state_next.winCount = 12'h000;
            end else if (state_reg.phase == wqw_pkg::OPEN_PHASE &&
                         state_reg.winCount >= openLen - 12'h001) begin
                timeout               = 1'b1;
                state_next.phase      = wqw_pkg::CLOSED_PHASE;
                state_next.winCount   = 12'h000;
                state_next.firstCycle = 1'b0;
            end else begin
                state_next.winCount = state_reg.winCount + 12'h001;
            end
        end

        // reset pulse ends at the next tick
        if (watchdogOn && tick) begin
            state_next.resetOut_n = 1'b1;
        end

        // failure counting; violations count too
        if (watchdogOn && (violation || timeout)) begin
            failSum = state_reg.failCount + 2'h1;
            if (violation) state_next.flags[wqw_pkg::VIOLATION_BIT] = 1'b1;
            if (timeout)   state_next.flags[wqw_pkg::TIMEOUT_BIT]   = 1'b1;
            if (failSum >= failLimit) begin
                state_next.failCount  = 2'h0;
                state_next.resetOut_n = 1'b0;
                state_next.flags[wqw_pkg::FAULT_BIT] = 1'b1;
                state_next.phase      = wqw_pkg::CLOSED_PHASE;
                state_next.winCount   = 12'h000;
            end else begin
                state_next.failCount = failSum;
            end
        end

        // registered read port
        if (regRead) begin
            unique case (regAddr)
                wqw_pkg::TIMING_CFG_ADDR:  state_next.readData = state_reg.timingCfg;
                wqw_pkg::WINDOW_CFG_ADDR:  state_next.readData = state_reg.windowCfg;
                wqw_pkg::ENABLE_CFG_ADDR:  state_next.readData = state_reg.enableCfg;
                wqw_pkg::SERVICE_KEY_ADDR: state_next.readData = state_reg.key;
                wqw_pkg::GUARD_ADDR:       state_next.readData = {7'h00, state_reg.guard};
                wqw_pkg::STATUS_ADDR:      state_next.readData = {3'h0, state_reg.failCount,
                                                                  state_reg.flags};
                default:                   state_next.readData = 8'h00;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.timingCfg  <= wqw_pkg::CFG_RESET;
            state_reg.windowCfg  <= wqw_pkg::CFG_RESET;
            state_reg.enableCfg  <= wqw_pkg::CFG_RESET;
            state_reg.guard      <= 1'b0;
            state_reg.key        <= wqw_pkg::KEY_RESET;
            state_reg.flags      <= wqw_pkg::STATUS_RESET[2:0];
            state_reg.readData   <= 8'h00;
            state_reg.phase      <= wqw_pkg::CLOSED_PHASE;
            state_reg.winCount   <= 12'h000;
            state_reg.firstCycle <= 1'b1;
            state_reg.failCount  <= 2'h0;
            state_reg.resetOut_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign regReadData      = state_reg.readData;
    assign systemResetOut_n = state_reg.resetOut_n;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_OFF_IDLE: assert property (!watchdogOn |=> state_reg.winCount == 12'h000 && systemResetOut_n)
        else $error("watchdog advanced while disabled");
    AST_KEY_READ: assert property (regRead && regAddr == wqw_pkg::SERVICE_KEY_ADDR |=> regReadData == $past(state_reg.key))
        else $error("key read mismatch");
    AST_SIMPLE_KEEP: assert property (keyWrite && simpleMode |=> $stable(state_reg.key) && state_reg.winCount == 12'h000)
        else $error("simple write changed key or did not refresh");
    AST_WRONG_ANSWER: assert property (keyWrite && !simpleMode && !answerRight |=> state_reg.flags[wqw_pkg::VIOLATION_BIT] && $stable(state_reg.key))
        else $error("wrong answer not flagged");
    AST_RIGHT_OPEN: assert property (keyWrite && !simpleMode && answerRight && state_reg.phase == wqw_pkg::OPEN_PHASE |=> state_reg.key == $past(expectedKey) && state_reg.phase == wqw_pkg::CLOSED_PHASE)
        else $error("right answer did not refresh");
    AST_RIGHT_CLOSED: assert property (keyWrite && !simpleMode && answerRight && state_reg.phase == wqw_pkg::CLOSED_PHASE |=> state_reg.flags[wqw_pkg::VIOLATION_BIT] && $stable(state_reg.key))
        else $error("early answer not flagged");
    AST_LFSR_STEP: assert property ($changed(state_reg.key) |-> state_reg.key == wqw_pkg::lfsr_next($past(state_reg.key)))
        else $error("key left the sequence");
    AST_GUARD_HOLD: assert property (state_reg.guard && regWrite |=> $stable(state_reg.timingCfg) && $stable(state_reg.windowCfg) && $stable(state_reg.enableCfg))
        else $error("guarded config changed");
    AST_SINGLE_FAIL: assert property (watchdogOn && keyWrite && !simpleMode && !answerRight && !state_reg.enableCfg[wqw_pkg::THRESHOLD_BIT] |=> !systemResetOut_n && state_reg.flags[wqw_pkg::FAULT_BIT])
        else $error("single failure did not reset");
    AST_OPEN_ON_TICK: assert property (state_reg.phase == wqw_pkg::CLOSED_PHASE ##1 state_reg.phase == wqw_pkg::OPEN_PHASE |-> $past(tick))
        else $error("window opened without tick");

    COV_QA_REFRESH: cover property (keyWrite && !simpleMode && answerRight && state_reg.phase == wqw_pkg::OPEN_PHASE);
    COV_TIMEOUT: cover property (state_next.flags[wqw_pkg::TIMEOUT_BIT] && !state_reg.flags[wqw_pkg::TIMEOUT_BIT]);
    COV_FAULT: cover property ($fell(systemResetOut_n));
    COV_SLOW_TICK: cover property (tick && state_reg.timingCfg[wqw_pkg::TICK_PRESCALE_BIT]);
endmodule // wqw_watchdog_regs
`default_nettype wire

// [tb/wqw_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// host side of the register port, driven off the falling edge
module wqw_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] regReadData,
    output logic      [7:0] regAddr,
    output logic            regWrite,
    output logic      [7:0] regWriteData,
    output logic            regRead
);
    ////////////////////////////////////////////////////////////////////////
    // idle port at time zero
    initial begin
        regAddr      = 8'h00;
        regWrite     = 1'b0;
        regWriteData = 8'h00;
        regRead      = 1'b0;
    end

    // next answer: shift left, taps x8 x6 x5 x4 fed into bit 0
    function automatic logic [7:0] next_key(input logic [7:0] k);
        next_key = {k[6:0], k[7] ^ k[5] ^ k[4] ^ k[3]};
    endfunction

    // one-cycle write strobe, held over one rising edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr      = a;
        regWriteData = d;
        regWrite     = 1'b1;
        @(negedge clk);
        regWrite     = 1'b0;
        regWriteData = ~d;
    endtask

    // one-cycle read strobe, data taken in the following cycle
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk);
        regRead = 1'b0;
        d       = regReadData;
    endtask
endmodule // wqw_host_model
`default_nettype wire

// [tb/wqw_watchdog_regs_tb.sv]
`timescale 1ns/10ps
`default_nettype none
// self-checking bench: host model drives, key and status modelled here
module wqw_watchdog_regs_tb;
    localparam int BASE = 4; // short tick base for simulation
    logic       clk;
    logic       reset_n;
    logic [7:0] regAddr;
    logic       regWrite;
    logic [7:0] regWriteData;
    logic       regRead;
    logic [7:0] regReadData;
    logic       sysResetOut_n;
    int         errorCnt;
    int         checkCount;
    logic [7:0] keyM;     // modelled key value
    logic [7:0] rd;       // last read value
    logic [7:0] rnd;      // random stimulus

    wqw_host_model wqw_host_model_i (
        .clk          (clk),
        .regReadData  (regReadData),
        .regAddr      (regAddr),
        .regWrite     (regWrite),
        .regWriteData (regWriteData),
        .regRead      (regRead)
    );

    wqw_watchdog_regs #(.BASE_CYCLES(BASE)) wqw_watchdog_regs_i (
        .clk              (clk),
        .reset_n          (reset_n),
        .regAddr          (regAddr),
        .regWrite         (regWrite),
        .regWriteData     (regWriteData),
        .regRead          (regRead),
        .regReadData      (regReadData),
        .systemResetOut_n (sysResetOut_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // compare and count
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // status value: live count, timeout, violation, fault
    function automatic logic [7:0] st(input bit f, input bit v, input bit t, input int c);
        st = {3'h0, c[1:0], t, v, f};
    endfunction

    // read a register and compare
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        wqw_host_model_i.read_reg(a, rd);
        check($sformatf("register %h", a), rd, exp);
    endtask

    // compare the fault reset output
    task automatic rst_chk(input logic exp);
        check("reset output", {7'h00, sysResetOut_n}, {7'h00, exp});
    endtask

    // bounded wait for the fault reset output to fall
    task automatic wait_reset_low(input int limit);
        int n;
        n = 0;
        while (sysResetOut_n !== 1'b0 && n < limit) begin
            @(negedge clk);
            n++;
        end
        rst_chk(1'b0);
        if (n >= limit) begin
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wqw_host_model_i.write_reg(a, d);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        errorCnt   = 0;
        checkCount = 0;
        keyM       = 8'h01;
        reset_n    = 1'b0;
        rnd        = 8'($urandom(32'h375BC237));
        repeat (4) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        // reset values and an unmapped place
        for (int a = 8'h13; a <= 8'h18; a++) begin
            rchk(8'(a), (a == 8'h16) ? keyM : 8'h00);
        end
        rchk(8'h20, 8'h00);
        // key write while off is ignored
        wr(8'h16, rnd);
        rchk(8'h16, keyM);
        rnd = 8'($urandom);
        wr(8'h14, rnd);
        rchk(8'h14, rnd);
        // qa mode, closed 8 ticks, open 16 ticks, extension x2, one failure
        wr(8'h13, 8'h00);
        wr(8'h14, 8'h01);
        wr(8'h15, 8'h09);
        rchk(8'h15, 8'h09);
        repeat (44) @(negedge clk);
        // right answer still in the stretched closed window
        wr(8'h16, wqw_host_model_i.next_key(keyM));
        rst_chk(1'b0);
        rchk(8'h18, st(1, 1, 0, 0));
        rchk(8'h16, keyM);
        wr(8'h18, 8'h07);
        rchk(8'h18, 8'h00);
        repeat (70) @(negedge clk);
        // right answer in the open window
        keyM = wqw_host_model_i.next_key(keyM);
        wr(8'h16, keyM);
        rchk(8'h16, keyM);
        rchk(8'h18, 8'h00);
        rst_chk(1'b1);
        // two failures needed, wrong answers
        wr(8'h15, 8'h19);
        wr(8'h16, ~wqw_host_model_i.next_key(keyM));
        rst_chk(1'b1);
        rchk(8'h18, st(0, 1, 0, 1));
        rchk(8'h16, keyM);
        wr(8'h16, ~wqw_host_model_i.next_key(keyM));
        rst_chk(1'b0);
        rchk(8'h18, st(1, 1, 0, 0));
        wr(8'h18, 8'h07);
        // no service: open window expiries
        repeat (96) @(negedge clk);
        rchk(8'h18, st(0, 0, 1, 1));
        wait_reset_low(150);
        rchk(8'h18, st(1, 0, 1, 0));
        wr(8'h18, 8'h07);
        // disabled watchdog stays quiet
        wr(8'h15, 8'h00);
        repeat (300) @(negedge clk);
        rchk(8'h18, 8'h00);
        rst_chk(1'b1);
        // slow tick: prescale x64, divider 1, shortest windows, one failure
        wr(8'h14, 8'h00);
        wr(8'h13, 8'h41);
        wr(8'h15, 8'h08);
        repeat (8150) @(negedge clk);
        rst_chk(1'b1);
        rchk(8'h18, 8'h00);
        wait_reset_low(100);
        rchk(8'h18, st(1, 0, 1, 0));
        wr(8'h15, 8'h00);
        wr(8'h14, 8'h01);
        wr(8'h18, 8'h07);
        // simple mode: any data refreshes, key kept
        wr(8'h13, 8'h80);
        wr(8'h15, 8'h08);
        for (int i = 0; i < 3; i++) begin
            rnd = 8'($urandom);
            wr(8'h16, rnd);
            rchk(8'h16, keyM);
            rchk(8'h18, 8'h00);
            repeat (60) @(negedge clk);
        end
        // guard makes the configuration read-only
        wr(8'h17, 8'h01);
        rchk(8'h17, 8'h01);
        wr(8'h14, rnd);
        wr(8'h15, 8'h00);
        rchk(8'h14, 8'h01);
        rchk(8'h15, 8'h08);
        end_of_test();
    end
endmodule // wqw_watchdog_regs_tb
`default_nettype wire
